// [bench/gcs_host.sv]
// Host controller model driving the pixel port
`timescale 1ns/1ps
module gcs_host (
  input  wire logic  clk,       // Clock
  output logic [23:0] pd_data,  // Pixel pins
  output logic       pd_valid,  // Strobe
  output logic       hsync_in,  // Line sync
  output logic       vsync_in,  // Field sync
  output logic       field_odd  // Odd field
);
  initial {pd_data, pd_valid, hsync_in, vsync_in, field_odd} = '0;
  // One idle cycle between pixels; idle pins show the inverse so stale data never matches
  task automatic line(input logic [23:0] base, input int n);
    vsync_in = 1'b1;
    hsync_in = 1'b1;
    repeat (3) @(negedge clk);
    {vsync_in, hsync_in} = 2'b00;
    repeat (3) @(negedge clk);
    for (int k = 0; k < n; k++)
    begin
      pd_data = base + 24'(k);
      pd_valid = 1'b1;
      @(negedge clk);
      pd_valid = 1'b0;
      pd_data = ~pd_data;
      @(negedge clk);
    end
  endtask
endmodule

// [bench/gcs_top_properties.sv]
// Port checker for the pixel pipeline top
`timescale 1ns/1ps
module gcs_top_chk (
  input wire logic       clk,            // Clock
  input wire logic       rst_b,          // Reset
  input wire logic [23:0] pd_data,       // Pixel
  input wire logic       pd_valid,       // Strobe
  input wire logic       cursor_en,      // Cursor on
  input wire logic       aux_mode,       // Aux mode
  input wire logic       enc_req,        // Request
  input wire logic       enc_active,     // Active
  input wire logic       flag_clear,     // Clear
  input wire logic [23:0] dac_rgb,       // Aux pixel
  input wire logic       dac_valid,      // Aux strobe
  input wire logic       enc_valid,      // Enc strobe
  input wire logic       fifo_overflow,  // Overflow
  input wire logic       fifo_underflow  // Underflow
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_dac_from_pin: assert property (dac_valid |-> $past(pd_valid, 3) && aux_mode)
    else $error("aux pixel without input pixel");
  a_aux_pass_through: assert property (dac_valid && !cursor_en |-> dac_rgb == $past(pd_data, 3))
    else $error("aux pixel value differs");
  a_aux_only: assert property (!aux_mode [*4] |-> !dac_valid)
    else $error("aux strobe outside aux mode");
  a_enc_answer: assert property (enc_req |=> enc_valid)
    else $error("encoder request unanswered");
  a_enc_cause: assert property (enc_valid |-> $past(enc_req))
    else $error("encoder strobe without request");
  a_ovf_sticky: assert property (fifo_overflow && !flag_clear |=> fifo_overflow)
    else $error("overflow flag lost");
  a_unf_sticky: assert property (fifo_underflow && !flag_clear |=> fifo_underflow)
    else $error("underflow flag lost");
  a_unf_cause: assert property ($rose(fifo_underflow) |-> $past(enc_req && enc_active))
    else $error("underflow without read");
  a_unf_clear: assert property (flag_clear && !enc_req |=> !fifo_underflow)
    else $error("underflow not cleared");
  c_cursor: cover property (dac_valid && cursor_en);
  c_ovf: cover property ($rose(fifo_overflow));
  c_unf: cover property ($rose(fifo_underflow));
endmodule
bind gcs_top gcs_top_chk u_chk (.*);

// [bench/gcs_top_test.sv]
// Self-checking bench for the pixel pipeline top
`timescale 1ns/1ps
module gcs_top_test;
  logic clk, rst_b, cursor_en, cursor_mode_select, bmap_from_port, bmap_wr, gain_en, ycc_input, aux_mode;
  logic studio_mode, vert_up4_mode, enc_req, enc_active, int_clk_from_pin, flag_clear, dto_vsync_clear;
  logic pd_valid, hsync_in, vsync_in, field_odd, dac_valid, enc_valid, fifo_overflow, fifo_underflow;
  logic pixel_clock, int_pixel_clock;
  logic [23:0] pd_data, cursor_col1, cursor_col2, cursor_aux, dto_inc, dac_rgb;
  logic [11:0] horiz_scale_increment, vert_scale_increment, flicker_skip_setting;
  logic [11:0] odd_field_initial_weight, even_field_initial_weight;
  logic [10:0] pos_x, pos_y, first_line, h_offset, h_count;
  logic [7:0] bmap_addr, bmap_wdata, border_y, border_cb, border_cr, enc_y, enc_c;
  logic [4:0] hot_x, hot_y;
  logic [1:0] ext_div, int_div;
  int err_count, cmp_count, cyc;
  logic [23:0] q[$];
  gcs_top DUT (.*);
  gcs_host host (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk)
    if (dac_valid === 1'b1)
      q.push_back(dac_rgb);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic t_fifo();
    chk("ovf", 24'(fifo_overflow), 24'h00_0000);
    host.line(24'h00_8040, 8);
    repeat (8) @(negedge clk);
    chk("ovf", 24'(fifo_overflow), 24'h00_0001);
    enc_active = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      enc_req = 1'b1;
      @(negedge clk);
      chk("enc_valid", 24'(enc_valid), 24'h00_0001);
      chk("enc_y", 24'(enc_y), (i < 4) ? 24'h00_0080 : 24'(border_y));
      enc_req = 1'b0;
      @(negedge clk);
    end
    chk("unf", 24'(fifo_underflow), 24'h00_0001);
    chk("border", 24'(enc_y), 24'(border_y));
    enc_active = 1'b0;
    flag_clear = 1'b1;
    @(negedge clk);
    flag_clear = 1'b0;
    @(negedge clk);
    chk("flags", 24'({fifo_overflow, fifo_underflow}), 24'h00_0000);
    $display("fifo test done");
  endtask
  task automatic t_load();
    bmap_from_port = 1'b1;
    first_line = 11'h001;
    // Strobe 769 carries 0xe4, the first bitmap byte
    host.line(24'h00_fde4, 1024);
    repeat (4) @(negedge clk);
    bmap_from_port = 1'b0;
    first_line = 11'h000;
    $display("load test done");
  endtask
  task automatic t_clk();
    logic [1:0] pk;
    pk = {pixel_clock, int_pixel_clock};
    repeat (2) @(negedge clk);
    chk("pixel_clock", 24'(pixel_clock), 24'(!pk[1]));
    repeat (2) @(negedge clk);
    chk("int_pixel_clock", 24'(int_pixel_clock), 24'(!pk[0]));
    $display("clock test done");
  endtask
  task automatic t_cur(input logic en, md);
    logic [23:0] p, e;
    aux_mode = 1'b1;
    cursor_en = en;
    cursor_mode_select = md;
    q.delete();
    host.line(24'h12_3450, 8);
    repeat (6) @(negedge clk);
    chk("count", 24'(q.size()), 24'h00_0008);
    for (int k = 0; k < 8 && k < q.size(); k++)
    begin
      p = 24'h12_3450 + 24'(k);
      e = (!en || k % 4 == 2) ? p : k % 4 == 0 ? cursor_col2 : k % 4 == 1 ? cursor_col1 : md ? cursor_aux : ~p;
      chk("dac_rgb", q[k], e);
    end
    $display("cursor test done");
  endtask
  initial
  begin
    {cursor_en, cursor_mode_select, bmap_from_port, bmap_wr, gain_en, studio_mode, vert_up4_mode} = '0;
    {enc_req, enc_active, int_clk_from_pin, flag_clear, dto_vsync_clear, aux_mode, ycc_input} = 7'h01;
    {hot_x, pos_x, first_line, h_offset, bmap_addr, bmap_wdata, ext_div} = '0;
    {horiz_scale_increment, vert_scale_increment} = '0;
    {hot_y, pos_y, h_count} = {5'h1f, 11'h01f, 11'h7ff};
    {odd_field_initial_weight, even_field_initial_weight} = {12'h0800, 12'h0400};
    int_div = 2'h1;
    flicker_skip_setting = 12'h0fff;
    {cursor_col1, cursor_col2, cursor_aux} = {24'h00_ff00, 24'h00_00ff, 24'hff_0000};
    {border_y, border_cb, border_cr, dto_inc} = {8'h5a, 8'h60, 8'ha0, 24'h40_0000};
    rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_fifo();
    t_load();
    // Byte 0 keeps the value the pixel port loaded
    for (int i = 1; i < 256; i++)
    begin
      bmap_addr = 8'(i);
      bmap_wdata = 8'he4;
      bmap_wr = 1'b1;
      @(negedge clk);
    end
    bmap_wr = 1'b0;
    t_cur(1'b0, 1'b0);
    t_cur(1'b1, 1'b0);
    t_cur(1'b1, 1'b1);
    t_clk();
    end_sim();
  end
endmodule

// [hdl/gcs_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module gcs_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst_b,     // Async reset, active low
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space available
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Read request
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// [hdl/gcs_pixel_clock_div.sv]
// Pixel clock divider by 1, 2, 4 or 8 driven by PHASE_ACCUMULATOR_OSC edge ticks
`timescale 1ns/1ps
module gcs_pixel_clock_div (
  input  wire logic       clk,     // System clock
  input  wire logic       rst_b,   // Async reset, active low
  input  wire logic       tick,    // One pulse per PHASE_ACCUMULATOR_OSC half period
  input  wire logic       reinit,  // Field start restart
  input  wire logic [1:0] ratio,   // 0:1 1:2 2:4 3:8
  output logic            div_clk  // Divided clock level
);
  logic [2:0] cnt_r;
  logic [2:0] top;

  assign top = 3'((4'd1 << ratio) - 4'd1);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r   <= '0;
      div_clk <= 1'b0;
    end
    else if (reinit)
    begin
      cnt_r   <= '0;
      div_clk <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt_r >= top)
      begin
        cnt_r   <= '0;
        div_clk <= ~div_clk;
      end
      else
        cnt_r <= cnt_r + 3'd1;
    end
  end
endmodule

// [hdl/gcs_pkg.sv]
// Types shared by the pixel pipeline
package gcs_pkg;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } gcs_rgb_s;
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
  } gcs_ycc_s;
  typedef struct packed {
    logic [23:0] data;
    logic        valid;
    logic        hsync;
    logic        vsync;
    logic        odd;
  } gcs_pin_s;
  typedef enum logic [1:0] {
    GCS_LD_IDLE = 2'b00,
    GCS_LD_LUT  = 2'b01,
    GCS_LD_BMAP = 2'b11,
    GCS_LD_DONE = 2'b10
  } gcs_load_e;
endpackage

// [hdl/gcs_regs.svh]
// Constants of the graphics cursor, scaler and pixel clock pipeline
`ifndef GCS_REGS_SVH
`define GCS_REGS_SVH
`define GCS_CUR_DIM      32
`define GCS_CUR_BYTES    256
`define GCS_LUT_BYTES    768
`define GCS_PHASE_ONE    4096
`define GCS_STUDIO_ONE   2048
`define GCS_SKIP_OFF     12'h0fff
`define GCS_VID_BLACK    16
`define GCS_CHROMA_MID   128
`define GCS_FIFO_DEPTH   4
`define GCS_FIFO_WIDTH   16
`define GCS_LINE_WORDS   2048
`define GCS_CLK_PERIOD_NS 10
`endif

// [hdl/gcs_top.sv]
// Cursor overlay, colour matrix, scalers, FIFO, border and pixel clock synthesis
`timescale 1ns/1ps
`include "gcs_regs.svh"
module gcs_top (
  input  wire logic        clk,              // 100 MHz system clock
  input  wire logic        rst_b,            // Async reset, active low
  input  wire logic [23:0] pd_data,          // Pixel data port pins
  input  wire logic        pd_valid,         // Pixel strobe pin
  input  wire logic        hsync_in,         // Line sync pin
  input  wire logic        vsync_in,         // Field sync pin
  input  wire logic        field_odd,        // Odd field pin
  input  wire logic        cursor_en,        // Cursor overlay on
  input  wire logic        cursor_mode_select, // Code 11: 0 invert, 1 aux colour
  input  wire logic [23:0] cursor_col1,      // First cursor colour
  input  wire logic [23:0] cursor_col2,      // Second cursor colour
  input  wire logic [23:0] cursor_aux,       // Auxiliary cursor colour
  input  wire logic [4:0]  hot_x,            // Hot spot column in bitmap
  input  wire logic [4:0]  hot_y,            // Hot spot row in bitmap
  input  wire logic [10:0] pos_x,            // Hot spot screen column
  input  wire logic [10:0] pos_y,            // Hot spot screen line
  input  wire logic        bmap_from_port,   // Bitmap loads over pixel port
  input  wire logic [10:0] first_line,       // First active line number
  input  wire logic        bmap_wr,          // Software bitmap write
  input  wire logic [7:0]  bmap_addr,        // Software bitmap byte index
  input  wire logic [7:0]  bmap_wdata,       // Software bitmap byte
  input  wire logic        gain_en,          // Map to 16..235
  input  wire logic        ycc_input,        // Input already 4:2:2 YCbCr
  input  wire logic        aux_mode,         // Auxiliary monitor mode
  input  wire logic        studio_mode,      // 656 input scaler mode
  input  wire logic [10:0] h_offset,         // Scaler start pixel
  input  wire logic [10:0] h_count,          // Scaler input pixel count
  input  wire logic [11:0] horiz_scale_increment, // Horizontal increment
  input  wire logic [11:0] vert_scale_increment,  // Vertical increment
  input  wire logic [11:0] odd_field_initial_weight,  // Odd field start phase
  input  wire logic [11:0] even_field_initial_weight, // Even field start phase
  input  wire logic [11:0] flicker_skip_setting,      // Flicker filter skip
  input  wire logic        vert_up4_mode,    // Extended vertical upscale
  input  wire logic [7:0]  border_y,         // Border tint luma
  input  wire logic [7:0]  border_cb,        // Border tint Cb
  input  wire logic [7:0]  border_cr,        // Border tint Cr
  input  wire logic        enc_req,          // Encoder sample request
  input  wire logic        enc_active,       // Encoder in active picture
  input  wire logic        int_clk_from_pin, // Internal clock from pixel pin
  input  wire logic        flag_clear,       // Clears FIFO error flags
  input  wire logic [23:0] dto_inc,          // Phase accumulator increment
  input  wire logic        dto_vsync_clear,  // Clear PHASE_ACCUMULATOR_OSC on V-sync
  input  wire logic [1:0]  ext_div,          // External divider ratio
  input  wire logic [1:0]  int_div,          // Internal divider ratio
  output logic [23:0]      dac_rgb,          // Auxiliary monitor pixel
  output logic             dac_valid,        // Auxiliary pixel strobe
  output logic [7:0]       enc_y,            // Encoder luma
  output logic [7:0]       enc_c,            // Encoder chroma, Cb/Cr alternate
  output logic             enc_valid,        // Encoder sample strobe
  output logic             fifo_overflow,    // Sticky overflow
  output logic             fifo_underflow,   // Sticky underflow
  output logic             pixel_clock,      // External pixel clock
  output logic             int_pixel_clock        // Internal pixel clock
);
  gcs_pkg::gcs_pin_s  s1_r;
  gcs_pkg::gcs_pin_s  s2_r;
  gcs_pkg::gcs_load_e ld_r;
  logic [7:0]  bmap_r [`GCS_CUR_BYTES];
  logic [15:0] line_r [`GCS_LINE_WORDS];
  logic        hs_d_r;
  logic        vs_d_r;
  logic        line_start;
  logic        field_start;
  logic [10:0] x_r;
  logic [10:0] y_r;
  logic [9:0]  ld_cnt_r;

  // Two-flop synchroniser for all pin inputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= {pd_data, pd_valid, hsync_in, vsync_in, field_odd};
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
    end
    else
    begin
      hs_d_r <= s2_r.hsync;
      vs_d_r <= s2_r.vsync;
    end
  end
  assign line_start  = s2_r.hsync && !hs_d_r;
  assign field_start = s2_r.vsync && !vs_d_r;

  // Input-resolution coordinates, origin at the upper left
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      x_r <= '0;
      y_r <= '0;
    end
    else
    begin
      if (line_start)
        x_r <= '0;
      else if (s2_r.valid)
        x_r <= x_r + 11'd1;
      if (field_start)
        y_r <= '0;
      else if (line_start)
        y_r <= y_r + 11'd1;
    end
  end

  // Bitmap upload: skip LUT bytes, then take 256 bytes, one per strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ld_r     <= gcs_pkg::GCS_LD_IDLE;
      ld_cnt_r <= '0;
    end
    else if (line_start)
    begin
      ld_cnt_r <= '0;
      ld_r     <= (bmap_from_port && ((field_start ? 11'd0 : y_r + 11'd1) == first_line - 11'd1)) ?
                  gcs_pkg::GCS_LD_LUT : gcs_pkg::GCS_LD_IDLE;
    end
    else if (s2_r.valid)
    begin
      unique case (ld_r)
        gcs_pkg::GCS_LD_IDLE: ;
        gcs_pkg::GCS_LD_LUT:
        begin
          if (ld_cnt_r == 10'(`GCS_LUT_BYTES - 1))
          begin
            ld_r     <= gcs_pkg::GCS_LD_BMAP;
            ld_cnt_r <= '0;
          end
          else
            ld_cnt_r <= ld_cnt_r + 10'd1;
        end
        gcs_pkg::GCS_LD_BMAP:
        begin
          if (ld_cnt_r == 10'(`GCS_CUR_BYTES - 1))
            ld_r <= gcs_pkg::GCS_LD_DONE;
          ld_cnt_r <= ld_cnt_r + 10'd1;
        end
        gcs_pkg::GCS_LD_DONE: ;
      endcase
    end
  end

  // Byte k = row*8 + column/4, row-major from the upper left
  always_ff @(posedge clk)
  begin
    if (ld_r == gcs_pkg::GCS_LD_BMAP && s2_r.valid && !line_start)
      bmap_r[ld_cnt_r[7:0]] <= s2_r.data[7:0];
    else if (bmap_wr)
      bmap_r[bmap_addr] <= bmap_wdata;
  end

  // Cursor overlay
  logic [10:0] eff_x;
  logic [10:0] eff_y;
  logic [11:0] rel_x;
  logic [11:0] rel_y;
  logic        in_cur;
  logic [7:0]  cur_byte;
  logic [1:0]  cur_code;
  logic [23:0] ov_pix;

  // Hot spot may not go past the left or upper edge, so clamp there
  assign eff_x  = (pos_x < 11'(hot_x)) ? 11'(hot_x) : pos_x;
  assign eff_y  = (pos_y < 11'(hot_y)) ? 11'(hot_y) : pos_y;
  assign rel_x  = {1'b0, x_r} - {1'b0, eff_x} + 12'(hot_x);
  assign rel_y  = {1'b0, y_r - first_line} - {1'b0, eff_y} + 12'(hot_y);
  assign in_cur = cursor_en && (rel_x < 12'(`GCS_CUR_DIM)) && (rel_y < 12'(`GCS_CUR_DIM)) &&
                  (y_r >= first_line);
  assign cur_byte = bmap_r[{rel_y[4:0], rel_x[4:2]}];
  assign cur_code = cur_byte[{rel_x[1:0], 1'b0} +: 2];

  always_comb
  begin
    ov_pix = s2_r.data;
    if (in_cur)
    begin
      unique case (cur_code)
        2'b00: ov_pix = cursor_col2;
        2'b01: ov_pix = cursor_col1;
        2'b10: ov_pix = s2_r.data;
        2'b11: ov_pix = cursor_mode_select ? cursor_aux : ~s2_r.data;
      endcase
    end
  end

  logic [23:0] ov_r;
  logic        ov_v_r;
  logic [10:0] ov_x_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ov_r      <= '0;
      ov_v_r    <= 1'b0;
      ov_x_r    <= '0;
      dac_rgb   <= '0;
      dac_valid <= 1'b0;
    end
    else
    begin
      ov_r      <= ov_pix;
      ov_v_r    <= s2_r.valid && !aux_mode && (y_r >= first_line);
      ov_x_r    <= x_r;
      dac_rgb   <= aux_mode ? ov_pix : '0;
      dac_valid <= aux_mode && s2_r.valid;
    end
  end

  // Colour matrix with optional studio-range gain
  function automatic logic [7:0] clip8(input logic signed [19:0] v);
    clip8 = (v < 0) ? 8'h00 : (v > 20'sd255) ? 8'hff : v[7:0];
  endfunction

  gcs_pkg::gcs_rgb_s  rgb;
  logic signed [19:0] r_s;
  logic signed [19:0] g_s;
  logic signed [19:0] b_s;
  logic signed [19:0] y_s;
  logic signed [19:0] cb_s;
  logic signed [19:0] cr_s;
  assign rgb = ov_r;
  assign r_s = 20'(rgb.r);
  assign g_s = 20'(rgb.g);
  assign b_s = 20'(rgb.b);

  always_comb
  begin
    if (gain_en)
    begin
      y_s  = 20'sd`GCS_VID_BLACK + ((20'sd66 * r_s + 20'sd129 * g_s + 20'sd25 * b_s + 20'sd128) >>> 8);
      cb_s = 20'sd`GCS_CHROMA_MID + ((20'sd112 * b_s - 20'sd38 * r_s - 20'sd74 * g_s) >>> 8);
      cr_s = 20'sd`GCS_CHROMA_MID + ((20'sd112 * r_s - 20'sd94 * g_s - 20'sd18 * b_s) >>> 8);
    end
    else
    begin
      y_s  = (20'sd77 * r_s + 20'sd150 * g_s + 20'sd29 * b_s + 20'sd128) >>> 8;
      cb_s = 20'sd`GCS_CHROMA_MID + ((20'sd127 * b_s - 20'sd43 * r_s - 20'sd84 * g_s) >>> 8);
      cr_s = 20'sd`GCS_CHROMA_MID + ((20'sd127 * r_s - 20'sd106 * g_s - 20'sd21 * b_s) >>> 8);
    end
  end

  // Two-tap chroma low-pass, then Cb/Cr interleave
  logic [7:0]  cb_p_r;
  logic [7:0]  cr_p_r;
  logic [8:0]  cb_f;
  logic [8:0]  cr_f;
  logic        c_ph_r;
  gcs_pkg::gcs_ycc_s mx_r;
  logic        mx_v_r;
  logic [10:0] mx_x_r;
  assign cb_f = 9'(clip8(cb_s)) + 9'(cb_p_r) + 9'd1;
  assign cr_f = 9'(clip8(cr_s)) + 9'(cr_p_r) + 9'd1;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cb_p_r <= 8'h80;
      cr_p_r <= 8'h80;
      c_ph_r <= 1'b0;
      mx_r   <= '0;
      mx_v_r <= 1'b0;
      mx_x_r <= '0;
    end
    else
    begin
      mx_v_r <= ov_v_r;
      mx_x_r <= ov_x_r;
      if (line_start)
        c_ph_r <= 1'b0;
      else if (ov_v_r)
      begin
        cb_p_r <= clip8(cb_s);
        cr_p_r <= clip8(cr_s);
        c_ph_r <= ~c_ph_r;
        if (ycc_input)
          mx_r <= ov_r[15:0];
        else
          mx_r <= {clip8(y_s), c_ph_r ? cr_f[8:1] : cb_f[8:1]};
      end
    end
  end

  // Horizontal scaler, 12-bit phase
  logic [12:0] hacc_r;
  logic [12:0] hsum;
  logic        h_win;
  logic        h_emit;
  logic        h_rep_r;
  logic        oc_ph_r;
  logic [10:0] ox_r;
  gcs_pkg::gcs_ycc_s hs_r;
  logic        hs_v_r;
  assign hsum  = {1'b0, hacc_r[11:0]} + 13'(horiz_scale_increment);
  assign h_win = mx_v_r && (mx_x_r >= h_offset) && (mx_x_r < h_offset + h_count);
  assign h_emit = studio_mode ? (hsum >= 13'(`GCS_STUDIO_ONE)) :
                  ((horiz_scale_increment == '0) || hsum[12]);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hacc_r  <= '0;
      h_rep_r <= 1'b0;
      oc_ph_r <= 1'b0;
      ox_r    <= '0;
      hs_r    <= '0;
      hs_v_r  <= 1'b0;
    end
    else
    begin
      hs_v_r <= 1'b0;
      if (line_start)
      begin
        hacc_r  <= '0;
        h_rep_r <= 1'b0;
        oc_ph_r <= 1'b0;
        ox_r    <= '0;
      end
      else if (h_win)
      begin
        // Studio upscale: a second copy leaves on the following cycle unless that cycle brings a windowed pixel
        if (studio_mode)
        begin
          h_rep_r <= hsum >= 13'(2 * `GCS_STUDIO_ONE);
          hacc_r  <= hsum - (h_emit ? 13'(`GCS_STUDIO_ONE) : 13'd0) -
                     ((hsum >= 13'(2 * `GCS_STUDIO_ONE)) ? 13'(`GCS_STUDIO_ONE) : 13'd0);
        end
        else
          hacc_r <= {1'b0, hsum[11:0]};
        if (h_emit)
        begin
          hs_r   <= mx_r;
          hs_v_r <= 1'b1;
        end
      end
      else if (h_rep_r)
      begin
        h_rep_r <= 1'b0;
        hs_v_r  <= 1'b1;
      end
      if (hs_v_r)
      begin
        oc_ph_r <= ~oc_ph_r;
        ox_r    <= ox_r + 11'd1;
      end
    end
  end

  // Chroma re-sequenced by output parity so 4:2:2 order survives scaling
  logic [7:0] cb_h_r;
  logic [7:0] cr_h_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cb_h_r <= 8'h80;
      cr_h_r <= 8'h80;
    end
    else if (h_win && h_emit)
    begin
      if (c_ph_r)
        cb_h_r <= mx_r.c;
      else
        cr_h_r <= mx_r.c;
    end
  end

  // Vertical scaler with field phase and flicker blend against previous line
  logic [12:0] vacc_r;
  logic [12:0] vsum;
  logic        v_keep_r;
  logic [1:0]  aff_k;
  logic [15:0] prev_w;
  logic [8:0]  y_dif;
  logic [11:0] y_adj;
  logic [7:0]  vy;
  gcs_pkg::gcs_ycc_s vs_out;
  assign vsum  = {1'b0, vacc_r[11:0]} + 13'(vert_scale_increment);
  // Larger skip gives a smaller blend weight; the extra filter is off in 4x mode
  assign aff_k = (flicker_skip_setting == `GCS_SKIP_OFF || vert_up4_mode) ? 2'd0 :
                 ~flicker_skip_setting[11:10];
  assign prev_w = line_r[ox_r];
  assign y_dif  = {1'b0, prev_w[15:8]} - {1'b0, hs_r.y};
  assign y_adj  = 12'($signed(y_dif) * $signed({1'b0, aff_k})) >>> 3;
  assign vy     = (aff_k == 2'd0) ? hs_r.y : 8'(hs_r.y + y_adj[7:0]);
  assign vs_out = {vy, oc_ph_r ? cr_h_r : cb_h_r};

  always_ff @(posedge clk)
  begin
    if (hs_v_r)
      line_r[ox_r] <= hs_r;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vacc_r   <= '0;
      v_keep_r <= 1'b1;
    end
    else if (field_start)
    begin
      // Weights of zero are not to be programmed, so the start phase is trusted
      vacc_r   <= {1'b0, s2_r.odd ? odd_field_initial_weight : even_field_initial_weight};
      v_keep_r <= 1'b1;
    end
    else if (line_start)
    begin
      vacc_r   <= {1'b0, vsum[11:0]};
      v_keep_r <= (vert_scale_increment == '0) || vsum[12];
    end
  end

  // Clock-domain FIFO, bypassed when the pin clock runs the core
  logic        f_in_rdy;
  logic        f_out_v;
  logic [15:0] f_out_d;
  logic        f_push;
  logic        f_pop;
  assign f_push = hs_v_r && v_keep_r && !int_clk_from_pin;
  assign f_pop  = enc_req && enc_active && !int_clk_from_pin;

  gcs_fifo #(
    .W (`GCS_FIFO_WIDTH),
    .D (`GCS_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (f_push),
    .in_ready  (f_in_rdy),
    .in_data   (vs_out),
    .out_valid (f_out_v),
    .out_ready (f_pop),
    .out_data  (f_out_d)
  );

  // Sticky error flags; a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fifo_overflow  <= 1'b0;
      fifo_underflow <= 1'b0;
    end
    else
    begin
      fifo_overflow  <= (f_push && !f_in_rdy) || (fifo_overflow && !flag_clear);
      fifo_underflow <= (f_pop && !f_out_v) || (fifo_underflow && !flag_clear);
    end
  end

  // Border generator and encoder output
  logic bc_ph_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enc_y     <= 8'h00;
      enc_c     <= 8'h80;
      enc_valid <= 1'b0;
      bc_ph_r   <= 1'b0;
    end
    else if (int_clk_from_pin)
    begin
      enc_valid <= hs_v_r && v_keep_r;
      enc_y     <= vs_out.y;
      enc_c     <= vs_out.c;
    end
    else
    begin
      enc_valid <= enc_req;
      if (enc_req)
      begin
        bc_ph_r <= ~bc_ph_r;
        if (enc_active && f_out_v)
        begin
          enc_y <= f_out_d[15:8];
          enc_c <= f_out_d[7:0];
        end
        else
        begin
          enc_y <= border_y;
          enc_c <= bc_ph_r ? border_cr : border_cb;
        end
      end
    end
  end

  // Pixel clock synthesis: PHASE_ACCUMULATOR_OSC, then two dividers reset each field
  logic [23:0] dto_r;
  logic        dto_msb_r;
  logic        dto_tick;
  logic        ext_clk;
  logic        int_clk;
  logic [1:0]  int_ratio;
  assign dto_tick  = dto_r[23] != dto_msb_r;
  assign int_ratio = (int_div == 2'd3) ? 2'd2 : int_div;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dto_r     <= '0;
      dto_msb_r <= 1'b0;
    end
    else
    begin
      dto_msb_r <= dto_r[23];
      if (field_start && dto_vsync_clear)
        dto_r <= '0;
      else
        dto_r <= dto_r + dto_inc;
    end
  end

  gcs_pixel_clock_div u_ext_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick    (dto_tick),
    .reinit  (field_start),
    .ratio   (ext_div),
    .div_clk (ext_clk)
  );

  gcs_pixel_clock_div u_int_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick    (dto_tick),
    .reinit  (field_start),
    .ratio   (int_ratio),
    .div_clk (int_clk)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pixel_clock <= 1'b0;
      int_pixel_clock  <= 1'b0;
    end
    else
    begin
      pixel_clock <= ext_clk;
      int_pixel_clock  <= int_clk;
    end
  end
endmodule
